// [rtl/aes_cbc_chaining_datapath.sv]
// Chaining datapath: byte registers, input/output XOR, block control.
// Assumes an Avalon-MM master (processor or DMA) on core_clk.
// What this block does
// - Chain encrypt feeds core input XOR chaining.
// - Data-flow value 0x01 selects XOR on input.
// - Data-flow value 0x02 selects XOR on output.
// - Bit 2 sets direction; clearing selects decryption.
// - Bits 1:0 select the key size.
// - Bit 3 enables core, starts block processing.
// - Completion sets bit 5 done, raises interrupt.
// - Writing 0x00 to block config resets module.
// - Sixteen result bytes read out in sequence.
// - Configuration kept; chaining continues across blocks.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module aes_cbc_chaining_datapath #(
    parameter int unsigned CORE_CYCLES = aes_cbc_pkg::CORE_LATENCY
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             done_irq
);

    localparam int unsigned BB = aes_cbc_pkg::BLOCK_BYTES;
    localparam int unsigned KB = aes_cbc_pkg::KEY_MAX_BYTES;

    aes_cbc_pkg::state_e     state_q;
    aes_cbc_pkg::block_cfg_s cfg_q;
    logic [7:0]   dflow_q;
    logic         done_q;
    logic [4:0]   bin_cnt_q;
    logic [5:0]   key_cnt_q;
    logic [3:0]   xin_cnt_q;
    logic [4:0]   out_cnt_q;
    logic [127:0] blk_q;
    logic [127:0] res_q;
    logic [31:0]  rdata_q;
    logic         wait_q;

    logic [127:0] bin_v, xin_v, core_out, xin_load_val;
    logic [255:0] key_v;
    logic         core_done, req, acc, stall, data_reg, wr_acc, rd_acc;
    logic         wr_bin, wr_xin, wr_key, rd_out, wr_bcfg, soft_rst;
    logic         start, xin_load;
    logic [5:0]   key_need;
    logic [7:0]   out_byte;
    logic [31:0]  rdata_d;

    // Bus decode; data registers hold off while the core runs
    assign req      = avs_read | avs_write;
    assign data_reg = (avs_address == aes_cbc_pkg::OFS_BLOCK_INPUT)
                    | (avs_address == aes_cbc_pkg::OFS_CHAIN_INPUT)
                    | (avs_address == aes_cbc_pkg::OFS_KEY_INPUT)
                    | (avs_address == aes_cbc_pkg::OFS_BLOCK_OUTPUT);
    assign stall    = data_reg & (state_q == aes_cbc_pkg::ST_RUN);
    assign acc      = req & ~wait_q;
    assign wr_acc   = acc & avs_write & avs_byteenable[0];
    assign rd_acc   = acc & avs_read;
    assign wr_bin   = wr_acc & (avs_address == aes_cbc_pkg::OFS_BLOCK_INPUT)
                    & (bin_cnt_q != aes_cbc_pkg::BLOCK_FULL);
    assign wr_xin   = wr_acc & (avs_address == aes_cbc_pkg::OFS_CHAIN_INPUT);
    assign wr_key   = wr_acc & (avs_address == aes_cbc_pkg::OFS_KEY_INPUT)
                    & (key_cnt_q != aes_cbc_pkg::KEY_BYTES_256);
    assign rd_out   = rd_acc & (avs_address == aes_cbc_pkg::OFS_BLOCK_OUTPUT);
    assign wr_bcfg  = wr_acc & (avs_address == aes_cbc_pkg::OFS_BLOCK_CFG);

    // Enable and direction both low means reset, 0x00 included
    assign soft_rst = wr_bcfg & ~avs_writedata[aes_cbc_pkg::BCFG_ENABLE]
                    & ~avs_writedata[aes_cbc_pkg::BCFG_ENCRYPT];

    // Key bytes needed for the selected size
    always_comb
    begin
        case (cfg_q.key_size)
            aes_cbc_pkg::KEY_192: key_need = aes_cbc_pkg::KEY_BYTES_192;
            aes_cbc_pkg::KEY_256: key_need = aes_cbc_pkg::KEY_BYTES_256;
            default:              key_need = aes_cbc_pkg::KEY_BYTES_128;
        endcase
    end

    // Block starts once data and the whole key have arrived
    assign start = (state_q == aes_cbc_pkg::ST_LOAD) & cfg_q.enable
                 & (bin_cnt_q == aes_cbc_pkg::BLOCK_FULL)
                 & (key_cnt_q >= key_need) & ~acc;

    // Output byte, combined with chaining in XOR-on-output mode
    always_comb
    begin
        out_byte = res_q[{out_cnt_q[3:0], 3'b000} +: 8];
        if (dflow_q == aes_cbc_pkg::DFLOW_XOR_OUT)
            out_byte = out_byte
                     ^ xin_v[{out_cnt_q[3:0], 3'b000} +: 8];
    end

    // Chaining register refill for the next block
    always_comb
    begin
        xin_load     = 1'b0;
        xin_load_val = res_q;
        if (core_done && dflow_q == aes_cbc_pkg::DFLOW_XOR_IN)
        begin
            xin_load     = 1'b1;
            xin_load_val = core_out;
        end
        else if (rd_out && out_cnt_q == 5'h0F
                 && dflow_q == aes_cbc_pkg::DFLOW_XOR_OUT)
        begin
            xin_load     = 1'b1;
            xin_load_val = blk_q;
        end
    end

    // Read data mux, sampled one cycle ahead of the accept edge
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            aes_cbc_pkg::OFS_BLOCK_OUTPUT: rdata_d = {24'h0, out_byte};
            aes_cbc_pkg::OFS_DATAFLOW_CFG: rdata_d = {24'h0, dflow_q};
            aes_cbc_pkg::OFS_BLOCK_CFG:
            begin
                rdata_d[aes_cbc_pkg::BCFG_KEY_LSB +: 2] = cfg_q.key_size;
                rdata_d[aes_cbc_pkg::BCFG_ENCRYPT]      = cfg_q.encrypt;
                rdata_d[aes_cbc_pkg::BCFG_ENABLE]       = cfg_q.enable;
                rdata_d[aes_cbc_pkg::BCFG_DONE]         = done_q;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Waitrequest drops for one cycle per request
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wait_q <= ~(req & wait_q & ~stall);
            if (req & wait_q & ~stall)
                rdata_q <= rdata_d;
        end
    end

    // Configuration registers survive from block to block
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cfg_q   <= '0;
            dflow_q <= aes_cbc_pkg::DFLOW_RESET;
        end
        else
        begin
            if (wr_bcfg)
            begin
                cfg_q.key_size <= avs_writedata[aes_cbc_pkg::BCFG_KEY_LSB +: 2];
                cfg_q.encrypt  <= avs_writedata[aes_cbc_pkg::BCFG_ENCRYPT];
                cfg_q.enable   <= avs_writedata[aes_cbc_pkg::BCFG_ENABLE];
            end
            if (soft_rst)
                dflow_q <= aes_cbc_pkg::DFLOW_RESET;
            else if (wr_acc && avs_address == aes_cbc_pkg::OFS_DATAFLOW_CFG)
                dflow_q <= avs_writedata[7:0];
        end
    end

    // Block sequencer
    always_ff @(posedge core_clk)
    begin
        if (srst || soft_rst)
            state_q <= aes_cbc_pkg::ST_IDLE;
        else
            case (state_q)
                aes_cbc_pkg::ST_IDLE:
                    if (cfg_q.enable)
                        state_q <= aes_cbc_pkg::ST_LOAD;
                aes_cbc_pkg::ST_LOAD:
                    if (!cfg_q.enable)
                        state_q <= aes_cbc_pkg::ST_IDLE;
                    else if (start)
                        state_q <= aes_cbc_pkg::ST_RUN;
                aes_cbc_pkg::ST_RUN:
                    if (core_done)
                        state_q <= aes_cbc_pkg::ST_LOAD;
                default: state_q <= aes_cbc_pkg::ST_IDLE;
            endcase
    end

    // Core input word: chaining XOR only in XOR-on-input mode
    always_ff @(posedge core_clk)
    begin
        if (srst)
            blk_q <= '0;
        else if (start)
            blk_q <= (dflow_q == aes_cbc_pkg::DFLOW_XOR_IN) ? (bin_v ^ xin_v)
                                                          : bin_v;
    end

    // Byte counters; a start rearms them for the next block
    always_ff @(posedge core_clk)
    begin
        if (srst || soft_rst || start)
        begin
            bin_cnt_q <= 5'h00;
            key_cnt_q <= 6'h00;
            xin_cnt_q <= 4'h0;
        end
        else
        begin
            if (wr_bin)
                bin_cnt_q <= bin_cnt_q + 5'h01;
            if (wr_key)
                key_cnt_q <= key_cnt_q + 6'h01;
            if (wr_xin)
                xin_cnt_q <= xin_cnt_q + 4'h1; // Wraps every 16 bytes
        end
    end

    // Result capture, readout pointer and sticky done flag
    always_ff @(posedge core_clk)
    begin
        if (srst || soft_rst)
        begin
            res_q     <= '0;
            out_cnt_q <= 5'h00;
            done_q    <= 1'b0;
        end
        else if (core_done)
        begin
            res_q     <= core_out;
            out_cnt_q <= 5'h00;
            done_q    <= 1'b1;
        end
        else
        begin
            if (start)
                done_q <= 1'b0;
            if (rd_out && out_cnt_q != aes_cbc_pkg::BLOCK_FULL)
                out_cnt_q <= out_cnt_q + 5'h01;
        end
    end

    // Block input bytes
    byte_store #(
        .DEPTH    (BB)
    ) u_bin (
        .core_clk (core_clk),
        .srst     (srst),
        .clear    (soft_rst),
        .wr_en    (wr_bin),
        .wr_idx   (bin_cnt_q[3:0]),
        .wr_byte  (avs_writedata[7:0]),
        .load_en  (1'b0),
        .load_val ('0),
        .bytes    (bin_v)
    );

    // Chaining register; the device refills it between blocks
    byte_store #(
        .DEPTH    (BB)
    ) u_xin (
        .core_clk (core_clk),
        .srst     (srst),
        .clear    (soft_rst),
        .wr_en    (wr_xin),
        .wr_idx   (xin_cnt_q),
        .wr_byte  (avs_writedata[7:0]),
        .load_en  (xin_load),
        .load_val (xin_load_val),
        .bytes    (xin_v)
    );

    // Key bytes, up to the longest key
    byte_store #(
        .DEPTH    (KB)
    ) u_key (
        .core_clk (core_clk),
        .srst     (srst),
        .clear    (soft_rst),
        .wr_en    (wr_key),
        .wr_idx   (key_cnt_q[4:0]),
        .wr_byte  (avs_writedata[7:0]),
        .load_en  (1'b0),
        .load_val ('0),
        .bytes    (key_v)
    );

    cipher_core #(
        .LATENCY  (CORE_CYCLES)
    ) u_core (
        .core_clk (core_clk),
        .srst     (srst | soft_rst),
        .start    (start),
        .encrypt  (cfg_q.encrypt),
        .key_size (cfg_q.key_size),
        .key      (key_v),
        .din      (blk_q),
        .busy     (),
        .done     (core_done),
        .dout     (core_out)
    );

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign done_irq        = done_q;

endmodule

// [pkg/aes_cbc_pkg.sv]
// Shared constants and types for the chaining datapath around the cipher.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package aes_cbc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_BLOCK_INPUT   = 8'h00;
    localparam logic [7:0] OFS_CHAIN_INPUT   = 8'h04;
    localparam logic [7:0] OFS_KEY_INPUT     = 8'h08;
    localparam logic [7:0] OFS_BLOCK_OUTPUT  = 8'h0C;
    localparam logic [7:0] OFS_DATAFLOW_CFG  = 8'h10;
    localparam logic [7:0] OFS_BLOCK_CFG     = 8'h14;

    // Block configuration field positions
    localparam int unsigned BCFG_KEY_LSB     = 0;
    localparam int unsigned BCFG_ENCRYPT     = 2;
    localparam int unsigned BCFG_ENABLE      = 3;
    localparam int unsigned BCFG_DONE        = 5;
    localparam logic [7:0]  BCFG_RESET       = 8'h00;

    // Data-flow selections
    localparam logic [7:0] DFLOW_PLAIN       = 8'h00;
    localparam logic [7:0] DFLOW_XOR_IN      = 8'h01;
    localparam logic [7:0] DFLOW_XOR_OUT     = 8'h02;
    localparam logic [7:0] DFLOW_RESET       = 8'h00;

    // Key sizes and byte counts
    typedef enum logic [1:0] {
        KEY_128 = 2'h0,
        KEY_192 = 2'h1,
        KEY_256 = 2'h2
    } key_size_e;
    localparam logic [5:0] KEY_BYTES_128     = 6'h10;
    localparam logic [5:0] KEY_BYTES_192     = 6'h18;
    localparam logic [5:0] KEY_BYTES_256     = 6'h20;
    localparam int unsigned KEY_MAX_BYTES    = 32;
    localparam int unsigned BLOCK_BYTES      = 16;
    localparam logic [4:0] BLOCK_FULL        = 5'h10;

    // Core processing time in clock cycles
    localparam int unsigned CORE_LATENCY     = 12;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b11
    } state_e;

    typedef struct packed {
        logic [1:0] key_size;
        logic       encrypt;
        logic       enable;
    } block_cfg_s;

endpackage

// [rtl/byte_store.sv]
// Byte-addressed flip-flop store with whole-vector load and clear.
// Assumes one byte write or one vector load per cycle; load wins.
`timescale 1ns/1ns
module byte_store #(
    parameter int unsigned DEPTH = 16
) (
    input  wire logic                     core_clk,
    input  wire logic                     srst,
    input  wire logic                     clear,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [7:0]               wr_byte,
    input  wire logic                     load_en,
    input  wire logic [DEPTH*8-1:0]       load_val,
    output logic      [DEPTH*8-1:0]       bytes
);

    logic [DEPTH-1:0][7:0] mem_q;

    // Byte writes land at the index given by the owner's counter
    always_ff @(posedge core_clk)
    begin
        if (srst || clear)
        begin
            mem_q <= '0;
        end
        else if (load_en)
        begin
            mem_q <= load_val;
        end
        else if (wr_en)
        begin
            mem_q[wr_idx] <= wr_byte;
        end
    end

    assign bytes = mem_q;

endmodule

// [rtl/cipher_core.sv]
// Stand-in block cipher: fixed latency, invertible keyed byte mix.
// Assumes din and key stay stable from start until done.
`timescale 1ns/1ns
module cipher_core #(
    parameter int unsigned LATENCY = aes_cbc_pkg::CORE_LATENCY
) (
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic         start,
    input  wire logic         encrypt,
    input  wire logic [1:0]   key_size,
    input  wire logic [255:0] key,
    input  wire logic [127:0] din,
    output logic              busy,
    output logic              done,
    output logic [127:0]      dout
);

    logic [7:0]   cnt_q;
    logic         done_q;
    logic [127:0] dout_q;
    logic [127:0] kf;
    logic [127:0] tmp;

    // Fold the longer keys into one 128-bit whitening word
    always_comb
    begin
        kf = key[127:0];
        if (key_size == aes_cbc_pkg::KEY_192)
        begin
            kf = key[127:0] ^ {64'h0, key[191:128]};
        end
        else if (key_size == aes_cbc_pkg::KEY_256)
        begin
            kf = key[127:0] ^ key[255:128];
        end
        tmp = din ^ kf;
    end

    // Latency counter; result captured on the last cycle
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cnt_q  <= 8'h00;
            done_q <= 1'b0;
            dout_q <= '0;
        end
        else
        begin
            done_q <= 1'b0;
            if (start)
            begin
                cnt_q <= 8'(LATENCY);
            end
            else if (cnt_q != 8'h00)
            begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01)
                begin
                    done_q <= 1'b1;
                    dout_q <= encrypt ? ({din[119:0], din[127:120]} ^ kf)
                                      : {tmp[7:0], tmp[127:8]};
                end
            end
        end
    end

    assign busy = (cnt_q != 8'h00);
    assign done = done_q;
    assign dout = dout_q;

endmodule

// [sim/aes_cbc_props.sv]
// Checker for the register port and done level of the chaining datapath.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module aes_cbc_props #(
    parameter int unsigned CORE_CYCLES = 12
) (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        done_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    logic       acc_wr;
    logic       acc_rd;
    logic [7:0] since_wr_q;

    // Accepted transfers
    assign acc_wr = avs_write && !avs_waitrequest;
    assign acc_rd = avs_read && !avs_waitrequest;

    // Cycles since the last accepted write, saturating
    always_ff @(posedge core_clk)
    begin
        if (srst || acc_wr)
            since_wr_q <= 8'h00;
        else if (since_wr_q != 8'hFF)
            since_wr_q <= since_wr_q + 8'h01;
    end

    AST_RESET_IDLE: assert property ($fell(srst) |-> avs_waitrequest && !done_irq)
        else $error("port not idle after reset");
    AST_SOFT_RESET: assert property (acc_wr && avs_byteenable[0]
        && avs_address == aes_cbc_pkg::OFS_BLOCK_CFG
        && avs_writedata[3:2] == 2'b00 |=> !done_irq)
        else $error("done kept after soft reset");
    AST_DONE_HOLD: assert property ($fell(done_irq) |-> $past(srst)
        || $past(acc_wr) || $past(acc_wr, 2) || $past(acc_wr, 3))
        else $error("done dropped without reset or start");
    AST_DONE_READBACK: assert property (acc_rd
        && avs_address == aes_cbc_pkg::OFS_BLOCK_CFG
        && done_irq == $past(done_irq) && done_irq == $past(done_irq, 2)
        |-> avs_readdata[aes_cbc_pkg::BCFG_DONE] == done_irq)
        else $error("done bit differs from done level");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low two cycles");
    AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> avs_read || avs_write)
        else $error("answer without request");
    AST_ANSWER_BOUND: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:40] !avs_waitrequest)
        else $error("request not answered in time");
    AST_DONE_LATENCY: assert property ($rose(done_irq)
        |-> since_wr_q >= 8'(CORE_CYCLES) && since_wr_q <= 8'(CORE_CYCLES + 6))
        else $error("done at wrong distance from start");

    // Main scenarios reached
    COV_DONE: cover property ($rose(done_irq));
    COV_OUT_READ: cover property (acc_rd
        && avs_address == aes_cbc_pkg::OFS_BLOCK_OUTPUT);
    COV_XOR_OUT: cover property (acc_wr
        && avs_address == aes_cbc_pkg::OFS_DATAFLOW_CFG
        && avs_writedata[7:0] == aes_cbc_pkg::DFLOW_XOR_OUT);
endmodule

// [sim/avl_host.sv]
// Register-port master standing in for the processor and its DMA channels.
// Assumes a free-running core_clk; one request at a time.
`timescale 1ns/1ns
module avl_host (
    input  wire logic        core_clk,
    input  wire logic        avs_waitrequest,
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable
);
    // Idle bus at time zero
    initial
    begin
        avs_address    = 8'hFF;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'h0;
    end

    // One access, held until accepted; ok stays low on a hang
    task automatic access(input logic rd, input logic [7:0] addr,
                          input logic [7:0] data, input logic [3:0] be,
                          output bit ok);
        ok = 1'b0;
        @(posedge core_clk);
        avs_address    <= addr;
        avs_writedata  <= {24'h000000, data};
        avs_byteenable <= be;
        avs_read       <= rd;
        avs_write      <= !rd;
        for (int n = 0; n < 200 && !ok; n++)
        begin
            @(posedge core_clk);
            ok = !avs_waitrequest;
        end
        // Released lines change so stale data cannot pass
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~addr;
        avs_writedata <= ~avs_writedata;
    endtask

    // Channel function code to the register it moves bytes through
    function automatic logic [7:0] route(input logic [7:0] code);
        case (code)
            8'h05:   return aes_cbc_pkg::OFS_KEY_INPUT;
            8'h06:   return aes_cbc_pkg::OFS_BLOCK_INPUT;
            8'h07:   return aes_cbc_pkg::OFS_CHAIN_INPUT;
            default: return aes_cbc_pkg::OFS_BLOCK_OUTPUT;
        endcase
    endfunction
endmodule

// [sim/tb_aes_cbc_chaining_datapath.sv]
// Self-checking bench for the chaining datapath through its register port.
// Assumes the host model drives the bus; the checker is bound at the foot.
`timescale 1ns/1ns
module tb_aes_cbc_chaining_datapath;
    localparam int unsigned CC = 2;
    logic         core_clk;
    logic         srst;
    logic [7:0]   avs_address;
    logic         avs_read;
    logic         avs_write;
    logic [31:0]  avs_writedata;
    logic [3:0]   avs_byteenable;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    logic         done_irq;
    int unsigned  fail_count;
    int unsigned  samples_checked;
    logic [7:0]   exp_q[$];
    logic [127:0] iv, p1, p2, c1, c2;
    logic [255:0] key;

    aes_cbc_chaining_datapath #(.CORE_CYCLES(CC)) dut_u (
        .core_clk(core_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .done_irq(done_irq));
    avl_host host_u (
        .core_clk(core_clk), .avs_waitrequest(avs_waitrequest),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Reads are checked in order of issue at their accept edge
    always @(posedge core_clk)
    begin
        if (avs_read && !avs_waitrequest)
        begin
            samples_checked++;
            if (exp_q.size() == 0 || avs_readdata[7:0] !== exp_q[0])
            begin
                fail_count++;
                $display("wrong value at %0t: read %h", $time, avs_readdata);
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked != 0 && exp_q.size() == 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic hang(input string what);
        fail_count++;
        $display("wrong value at %0t: no %s", $time, what);
        close_out();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be = 4'hF);
        bit ok;
        host_u.access(1'b0, a, d, be, ok);
        if (!ok)
            hang("write answer");
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        bit ok;
        exp_q.push_back(e);
        host_u.access(1'b1, a, 8'h00, 4'hF, ok);
        if (!ok)
            hang("read answer");
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done_irq !== 1'b1 && n < 500)
        begin
            @(posedge core_clk);
            n++;
        end
        if (done_irq !== 1'b1)
            hang("done");
    endtask

    // Expected cipher output from the stand-in core definition
    function automatic logic [127:0] kfold(input logic [255:0] k,
                                           input logic [1:0] ks);
        case (ks)
            aes_cbc_pkg::KEY_192: return k[127:0] ^ {64'h0, k[191:128]};
            aes_cbc_pkg::KEY_256: return k[127:0] ^ k[255:128];
            default: return k[127:0];
        endcase
    endfunction
    function automatic logic [127:0] enc(input logic [127:0] d,
                                         input logic [127:0] kf);
        return {d[119:0], d[127:120]} ^ kf;
    endfunction
    function automatic logic [127:0] dec(input logic [127:0] y,
                                         input logic [127:0] kf);
        logic [127:0] t;
        t = y ^ kf;
        return {t[7:0], t[127:8]};
    endfunction
    function automatic logic [127:0] rnd();
        return {$urandom(), $urandom(), $urandom(), $urandom()};
    endfunction

    // Interleaved block load, long-key tail, then wait for done
    task automatic feed(input logic [127:0] d, input logic [127:0] c,
                        input logic [255:0] k, input int nkey, input bit xin);
        for (int i = 0; i < 16; i++)
        begin
            wr(host_u.route(8'h06), d[8*i +: 8]);
            if (xin)
                wr(host_u.route(8'h07), c[8*i +: 8]);
            wr(host_u.route(8'h05), k[8*i +: 8]);
        end
        for (int i = 16; i < nkey; i++)
            wr(host_u.route(8'h05), k[8*i +: 8]);
        // Old done stands until the start edge clears it
        repeat (2) @(posedge core_clk);
        wait_done();
    endtask

    // Sixteen output reads, chain bytes written first when asked
    task automatic drain(input logic [127:0] e, input logic [127:0] c,
                         input bit xin);
        for (int i = 0; i < 16; i++)
        begin
            if (xin)
                wr(aes_cbc_pkg::OFS_CHAIN_INPUT, c[8*i +: 8]);
            chk_rd(host_u.route(8'h08), e[8*i +: 8]);
        end
    endtask

    initial
    begin
        fail_count = 0;
        samples_checked = 0;
        srst = 1'b1;
        void'($urandom(32'hF4B6CE34));
        iv = rnd();
        p1 = rnd();
        p2 = rnd();
        c2 = rnd();
        key = {rnd(), rnd()};
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        chk_rd(aes_cbc_pkg::OFS_BLOCK_CFG, 8'h00);
        chk_rd(8'h30, 8'h00);
        // Chained encryption, 192-bit key, two blocks
        wr(aes_cbc_pkg::OFS_BLOCK_CFG, aes_cbc_pkg::BCFG_RESET);
        wr(aes_cbc_pkg::OFS_DATAFLOW_CFG, aes_cbc_pkg::DFLOW_XOR_IN);
        wr(aes_cbc_pkg::OFS_DATAFLOW_CFG, aes_cbc_pkg::DFLOW_XOR_OUT, 4'h0);
        chk_rd(aes_cbc_pkg::OFS_DATAFLOW_CFG, aes_cbc_pkg::DFLOW_XOR_IN);
        wr(aes_cbc_pkg::OFS_BLOCK_CFG, 8'h0D);
        feed(p1, iv, key, 24, 1'b1);
        chk_rd(aes_cbc_pkg::OFS_BLOCK_CFG, 8'h2D);
        c1 = enc(p1 ^ iv, kfold(key, aes_cbc_pkg::KEY_192));
        drain(c1, iv, 1'b0);
        feed(p2, iv, key, 24, 1'b0);
        drain(enc(p2 ^ c1, kfold(key, aes_cbc_pkg::KEY_192)), iv, 1'b0);
        chk_rd(aes_cbc_pkg::OFS_BLOCK_CFG, 8'h2D);
        // Soft reset clears done and data flow
        wr(aes_cbc_pkg::OFS_BLOCK_CFG, aes_cbc_pkg::BCFG_RESET);
        chk_rd(aes_cbc_pkg::OFS_BLOCK_CFG, 8'h00);
        chk_rd(aes_cbc_pkg::OFS_DATAFLOW_CFG, aes_cbc_pkg::DFLOW_RESET);
        // Chained decryption, 256-bit key, chain fed during readout
        wr(aes_cbc_pkg::OFS_DATAFLOW_CFG, aes_cbc_pkg::DFLOW_XOR_OUT);
        wr(aes_cbc_pkg::OFS_BLOCK_CFG, 8'h0A);
        feed(c1, iv, key, 32, 1'b0);
        drain(dec(c1, kfold(key, aes_cbc_pkg::KEY_256)) ^ iv, iv, 1'b1);
        feed(c2, iv, key, 32, 1'b0);
        drain(dec(c2, kfold(key, aes_cbc_pkg::KEY_256)) ^ c1, iv, 1'b0);
        // 128-bit key, one chained block, then a hard reset with done set
        wr(aes_cbc_pkg::OFS_BLOCK_CFG, aes_cbc_pkg::BCFG_RESET);
        wr(aes_cbc_pkg::OFS_DATAFLOW_CFG, aes_cbc_pkg::DFLOW_XOR_IN);
        wr(aes_cbc_pkg::OFS_BLOCK_CFG, 8'h0C);
        feed(p2, iv, key, 16, 1'b1);
        drain(enc(p2 ^ iv, key[127:0]), iv, 1'b0);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        chk_rd(aes_cbc_pkg::OFS_BLOCK_CFG, 8'h00);
        repeat (4) @(posedge core_clk);
        close_out();
    end
endmodule

bind aes_cbc_chaining_datapath
    aes_cbc_props #(.CORE_CYCLES(CORE_CYCLES)) props_u (
    .core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .done_irq(done_irq));
